// ---- logic/ors_sequencer.sv ----
// output ramp sequencer: run line, delay, soft-start ramp, gpio, servo
`default_nettype none
// Functional notes
// - hold run low until init and input ok
// - shared run line rises for all together
// - wait turn-on delay after run release
// - delay and ramp timing from shared timebase, fastest governs
// - step target from 0V to set point
// - rise under 0.250ms skips the ramp
// - one ramp step every 0.1ms
// - discontinuous mode during the rise ramp
// - gpio releases above undervoltage limit
// - unfiltered uv path gets 70us deglitch
// - servo only while mode bit 6 set
// - servo moves dac one lsb each 90ms
// - zero limit: ramp done, uv ok, no oc
// - leave forced discontinuous when servo eligible
// - ignore action: ramp, expiry, uv ok or no oc
// - other action: ramp, expiry, no uv, no oc
// - rise time limited to 1.3 seconds
// - input below off threshold pulls timebase low
module ors_sequencer
   import ors_pkg::*;
#(
   parameter int unsigned SERVO_CYCLES = SERVO_CYC,
   parameter int unsigned TMAX_TICK_CYCLES = TMAX_TICK_CYC
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // shared run line (open drain)
   input wire logic run_in,
   output logic run_out,
   output logic run_oe,
   // shared timebase line (open drain)
   input wire logic timebase_in,
   output logic timebase_out,
   output logic timebase_oe,
   // analog comparator inputs and adc reading
   input wire logic input_above_on,
   input wire logic input_below_off,
   input wire logic uv_comp_raw,
   input wire logic uv_filtered,
   input wire logic oc_active,
   input wire logic [15:0] adc_reading,
   // gpio power-good (open drain)
   output logic gpio_out,
   output logic gpio_oe,
   // power stage control
   output logic [15:0] ref_target,
   output logic [15:0] ref_dac,
   output logic force_discontinuous,
   output logic [1:0] conv_mode
);
   ////////////////////////////////////////////////////////////////////////
   logic [31:0] ctrl;
   logic [15:0] delay_ticks;
   logic [15:0] rise_ticks;
   logic [15:0] vset;
   logic [15:0] tmax_ms;
   logic [15:0] target;
   logic [31:0] status;
   logic run_lvl;
   logic tb_lvl;
   logic on_lvl;
   logic off_lvl;
   logic uvr_lvl;
   logic uvf_lvl;
   logic oc_lvl;

   typedef struct packed
   {
      ors_state_e st;
      logic tb_prev;
      logic [15:0] cnt;
      logic [15:0] ramp_len;
      logic [31:0] acc;
      logic [15:0] tgt;
      logic [15:0] dac;
      logic [31:0] svc;
      logic [31:0] tmc;
      logic [15:0] tms;
      logic tmax_done;
      logic [15:0] flt;
      logic uv_clean;
      logic gpio_rel;
      logic run_rel;
      logic tb_pull;
      logic fdcm;
      logic servo_ok;
   } ors_core_s;
   ors_core_s st_r;
   ors_core_s st_nxt;

   ors_apb_regs u_regs
   (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .ctrl(ctrl),
      .delay_ticks(delay_ticks),
      .rise_ticks(rise_ticks),
      .vset(vset),
      .tmax_ms(tmax_ms),
      .target(target),
      .status(status),
      .dac_code(st_r.dac)
   );

   ////////////////////////////////////////////////////////////////////////
   // pins and comparators from outside the clock domain
   logic [6:0] raw_in;
   logic [6:0] clean;
   assign raw_in = {run_in, timebase_in, input_above_on, input_below_off,
                    uv_comp_raw, uv_filtered, oc_active};
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++)
      begin : g_sync
         ors_sync3 u_sync
         (
            .pclk(pclk),
            .presetn(presetn),
            .pin_in(raw_in[gi]),
            .level_out(clean[gi])
         );
      end
   endgenerate
   assign {run_lvl, tb_lvl, on_lvl, off_lvl, uvr_lvl, uvf_lvl, oc_lvl} = clean;

   ////////////////////////////////////////////////////////////////////////
   logic tick;
   logic uv_ok;
   logic eligible;
   logic [15:0] rise_eff;
   logic [15:0] max_steps;
   localparam logic [15:0] SKIP_STEPS = 16'((RAMP_SKIP_US + STEP_US - 1) / STEP_US);
   localparam logic [15:0] MAX_STEPS = 16'(RAMP_MAX_US / STEP_US);

   always_comb
   begin
      st_nxt = st_r;
      tick = tb_lvl && !st_r.tb_prev;
      st_nxt.tb_prev = tb_lvl;
      max_steps = MAX_STEPS;
      rise_eff = (rise_ticks > max_steps) ? max_steps : rise_ticks;
      // source of gpio release
      // uv inputs high mean output below its limit
      uv_ok = ctrl[CTRL_GPIO_UNF_BIT] ? !st_r.uv_clean : !uvf_lvl;
      // deglitch: raw level must hold 70us
      if (uvr_lvl == st_r.uv_clean)
      begin
         st_nxt.flt = 16'h0000;
      end
      else if (st_r.flt >= 16'(UV_FILT_CYC - 1))
      begin
         st_nxt.flt = 16'h0000;
         st_nxt.uv_clean = uvr_lvl;
      end
      else
      begin
         st_nxt.flt = st_r.flt + 16'h0001;
      end
      // servo start condition per turn-on limit setting
      if (tmax_ms == 16'h0000)
      begin
         eligible = uv_ok && !oc_lvl;
      end
      else if (ctrl[CTRL_ACTION_LSB +: 8] == ACTION_IGNORE)
      begin
         eligible = st_r.tmax_done && (uv_ok || !oc_lvl);
      end
      else
      begin
         eligible = st_r.tmax_done && uv_ok && !oc_lvl;
      end
      // turn-on limit timer runs from run release
      if (st_r.st inside {ORS_DELAY, ORS_RAMP, ORS_SETTLE} && !st_r.tmax_done)
      begin
         if (st_r.tmc >= TMAX_TICK_CYCLES - 1)
         begin
            st_nxt.tmc = '0;
            st_nxt.tms = st_r.tms + 16'h0001;
            if (st_r.tms + 16'h0001 >= tmax_ms)
            begin
               st_nxt.tmax_done = 1'b1;
            end
         end
         else
         begin
            st_nxt.tmc = st_r.tmc + 32'h0000_0001;
         end
      end
      st_nxt.gpio_rel = uv_ok && (st_r.st != ORS_OFF);
      if (off_lvl)
      begin
         st_nxt.st = ORS_OFF;
         st_nxt.tb_pull = 1'b1;
         st_nxt.run_rel = 1'b0;
         st_nxt.tgt = 16'h0000;
         st_nxt.fdcm = 1'b1;
         st_nxt.servo_ok = 1'b0;
         st_nxt.gpio_rel = 1'b0;
      end
      else
      begin
         unique case (st_r.st)
            ORS_OFF:
            begin
               st_nxt.tgt = 16'h0000;
               st_nxt.fdcm = 1'b1;
               st_nxt.tmax_done = 1'b0;
               st_nxt.tms = 16'h0000;
               st_nxt.tmc = '0;
               // release only after init and input ok
               if (ctrl[CTRL_INIT_DONE_BIT] && on_lvl)
               begin
                  st_nxt.tb_pull = 1'b0;
                  st_nxt.run_rel = 1'b1;
                  st_nxt.st = ORS_WAIT_RUN;
               end
            end
            ORS_WAIT_RUN:
            begin
               // wait for every peer to let go
               if (run_lvl)
               begin
                  st_nxt.cnt = 16'h0000;
                  st_nxt.st = ORS_DELAY;
               end
            end
            ORS_DELAY:
            begin
               if (st_r.cnt >= delay_ticks)
               begin
                  st_nxt.cnt = 16'h0000;
                  st_nxt.acc = '0;
                  st_nxt.ramp_len = rise_eff;
                  // short rise applies set point directly
                  if (rise_eff < SKIP_STEPS)
                  begin
                     st_nxt.tgt = vset;
                     st_nxt.st = ORS_SETTLE;
                  end
                  else
                  begin
                     st_nxt.st = ORS_RAMP;
                  end
               end
               else if (tick)
               begin
                  st_nxt.cnt = st_r.cnt + 16'h0001;
               end
            end
            ORS_RAMP:
            begin
               if (tick)
               begin
                  // linear target from zero to set point
                  st_nxt.cnt = st_r.cnt + 16'h0001;
                  st_nxt.acc = st_r.acc + {16'h0000, vset};
                  st_nxt.tgt = 16'((st_r.acc + {16'h0000, vset}) / {16'h0000, st_r.ramp_len});
                  if (st_r.cnt + 16'h0001 >= st_r.ramp_len)
                  begin
                     st_nxt.tgt = vset;
                     st_nxt.st = ORS_SETTLE;
                  end
               end
            end
            ORS_SETTLE:
            begin
               st_nxt.tgt = vset;
               if (eligible)
               begin
                  st_nxt.fdcm = 1'b0;
                  st_nxt.servo_ok = 1'b1;
                  st_nxt.svc = '0;
                  st_nxt.st = ORS_ON;
               end
            end
            ORS_ON:
            begin
               st_nxt.tgt = vset;
            end
            default:
            begin
               st_nxt.st = ORS_OFF;
            end
         endcase
      end
      // servo gated by mode bit 6
      if (st_r.servo_ok && ctrl[CTRL_MODE_LSB + MODE_SERVO_BIT] && st_r.st == ORS_ON)
      begin
         if (st_r.svc >= SERVO_CYCLES - 1)
         begin
            st_nxt.svc = '0;
            if (adc_reading < target && st_r.dac != 16'hffff)
            begin
               st_nxt.dac = st_r.dac + 16'h0001;
            end
            else if (adc_reading > target && st_r.dac != 16'h0000)
            begin
               st_nxt.dac = st_r.dac - 16'h0001;
            end
         end
         else
         begin
            st_nxt.svc = st_r.svc + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= '{st: ORS_OFF, tb_prev: 1'b0, cnt: 16'h0000, ramp_len: 16'h0000,
                   acc: 32'h0000_0000, tgt: 16'h0000, dac: 16'h0000, svc: 32'h0000_0000,
                   tmc: 32'h0000_0000, tms: 16'h0000, tmax_done: 1'b0, flt: 16'h0000,
                   uv_clean: 1'b0, gpio_rel: 1'b0, run_rel: 1'b0, tb_pull: 1'b1,
                   fdcm: 1'b1, servo_ok: 1'b0};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status: range bit only scales the lsb meaning, logic counts codes
   assign status = {16'h0000, 4'h0, st_r.tmax_done, st_r.servo_ok, st_r.fdcm,
                    st_r.gpio_rel, st_r.run_rel, run_lvl, oc_lvl, uv_ok, 1'b0, st_r.st};
   // open drain: enable pulls low
   assign run_out = 1'b0;
   assign run_oe = !st_r.run_rel;
   assign timebase_out = 1'b0;
   assign timebase_oe = st_r.tb_pull;
   assign gpio_out = 1'b0;
   assign gpio_oe = !st_r.gpio_rel;
   assign ref_target = st_r.tgt;
   assign ref_dac = st_r.dac;
   assign force_discontinuous = st_r.fdcm;
   assign conv_mode = ctrl[CTRL_MODE_LSB +: 2];
endmodule // ors_sequencer
`default_nettype wire

// ---- logic/ors_pkg.sv ----
// package: constants and types for the output ramp sequencer
`default_nettype none
package ors_pkg;
   // clock rate
   localparam int unsigned CLK_HZ = 10_000_000;
   // ramp step interval and skip threshold, microseconds
   localparam int unsigned STEP_US = 100;
   localparam int unsigned RAMP_SKIP_US = 250;
   localparam int unsigned RAMP_MAX_US = 1_300_000;
   // deglitch filter time, nanoseconds
   localparam int unsigned UV_FILT_NS = 70_000;
   localparam int unsigned UV_FILT_CYC = (UV_FILT_NS / 100 > 0) ? UV_FILT_NS / 100 : 1;
   // servo period, milliseconds
   localparam int unsigned SERVO_MS = 90;
   localparam int unsigned SERVO_CYC = SERVO_MS * (CLK_HZ / 1000);
   // turn-on max limit tick: one millisecond
   localparam int unsigned TMAX_TICK_CYC = CLK_HZ / 1000;
   // register map (byte offsets)
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_DELAY = 12'h004;
   localparam logic [11:0] OFS_RISE = 12'h008;
   localparam logic [11:0] OFS_VSET = 12'h00c;
   localparam logic [11:0] OFS_TMAX = 12'h010;
   localparam logic [11:0] OFS_STAT = 12'h014;
   localparam logic [11:0] OFS_TARGET = 12'h018;
   localparam logic [11:0] OFS_DAC = 12'h01c;
   // conversion mode config field positions
   localparam int unsigned MODE_SERVO_BIT = 6;
   // ctrl register layout
   localparam int unsigned CTRL_INIT_DONE_BIT = 0;
   localparam int unsigned CTRL_GPIO_UNF_BIT = 1;
   localparam int unsigned CTRL_RANGE_BIT = 2;
   localparam int unsigned CTRL_MODE_LSB = 8;
   localparam int unsigned CTRL_ACTION_LSB = 16;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [15:0] DELAY_RST = 16'h0000;
   localparam logic [15:0] RISE_RST = 16'h0000;
   localparam logic [15:0] VSET_RST = 16'h0000;
   localparam logic [15:0] TMAX_RST = 16'h0000;
   localparam logic [7:0] ACTION_IGNORE = 8'h00;
   // sequencer states
   typedef enum logic [2:0]
   {
      ORS_OFF = 3'b000,
      ORS_WAIT_RUN = 3'b001,
      ORS_DELAY = 3'b010,
      ORS_RAMP = 3'b011,
      ORS_SETTLE = 3'b100,
      ORS_ON = 3'b101
   } ors_state_e;
endpackage : ors_pkg
`default_nettype wire

// ---- logic/ors_sync3.sv ----
// three-stage pin synchroniser with agreement filter
`default_nettype none
module ors_sync3
   import ors_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // pin in, clean level out
   input wire logic pin_in,
   output logic level_out
);
   typedef struct packed
   {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } ors_sync_s;
   ors_sync_s st_r;
   ors_sync_s st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.s1 = pin_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // change counts only once second and third stage agree
      if (st_r.s2 == st_r.s3)
      begin
         st_nxt.lvl = st_r.s3;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign level_out = st_r.lvl;
endmodule // ors_sync3
`default_nettype wire

// ---- logic/ors_apb_regs.sv ----
// apb slave holding the sequencer configuration registers
`default_nettype none
module ors_apb_regs
   import ors_pkg::*;
(
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // configuration out
   output logic [31:0] ctrl,
   output logic [15:0] delay_ticks,
   output logic [15:0] rise_ticks,
   output logic [15:0] vset,
   output logic [15:0] tmax_ms,
   output logic [15:0] target,
   // status in
   input wire logic [31:0] status,
   input wire logic [15:0] dac_code
);
   typedef struct packed
   {
      logic [31:0] ctrl;
      logic [15:0] dly;
      logic [15:0] rise;
      logic [15:0] vset;
      logic [15:0] tmax;
      logic [15:0] tgt;
      logic [31:0] rdata;
      logic err;
      logic rdy;
   } ors_regs_s;
   ors_regs_s st_r;
   ors_regs_s st_nxt;
   logic hit;

   always_comb
   begin
      st_nxt = st_r;
      hit = 1'b1;
      st_nxt.rdy = 1'b0;
      st_nxt.err = 1'b0;
      // answer one cycle into the access phase
      if (psel && penable && !st_r.rdy)
      begin
         st_nxt.rdy = 1'b1;
         st_nxt.rdata = 32'h0000_0000;
         unique case (paddr)
            OFS_CTRL: st_nxt.rdata = st_r.ctrl;
            OFS_DELAY: st_nxt.rdata = {16'h0000, st_r.dly};
            OFS_RISE: st_nxt.rdata = {16'h0000, st_r.rise};
            OFS_VSET: st_nxt.rdata = {16'h0000, st_r.vset};
            OFS_TMAX: st_nxt.rdata = {16'h0000, st_r.tmax};
            OFS_STAT: st_nxt.rdata = status;
            OFS_TARGET: st_nxt.rdata = {16'h0000, st_r.tgt};
            OFS_DAC: st_nxt.rdata = {16'h0000, dac_code};
            default: hit = 1'b0;
         endcase
         st_nxt.err = !hit;
         if (pwrite && hit)
         begin
            unique case (paddr)
               OFS_CTRL: st_nxt.ctrl = pwdata;
               OFS_DELAY: st_nxt.dly = pwdata[15:0];
               OFS_RISE: st_nxt.rise = pwdata[15:0];
               OFS_VSET: st_nxt.vset = pwdata[15:0];
               OFS_TMAX: st_nxt.tmax = pwdata[15:0];
               OFS_TARGET: st_nxt.tgt = pwdata[15:0];
               default: st_nxt.rdata = st_nxt.rdata;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= '{ctrl: CTRL_RST, dly: DELAY_RST, rise: RISE_RST, vset: VSET_RST,
                   tmax: TMAX_RST, tgt: 16'h0000, rdata: 32'h0000_0000,
                   err: 1'b0, rdy: 1'b0};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.rdata;
   assign pready = st_r.rdy;
   assign pslverr = st_r.err;
   assign ctrl = st_r.ctrl;
   assign delay_ticks = st_r.dly;
   assign rise_ticks = st_r.rise;
   assign vset = st_r.vset;
   assign tmax_ms = st_r.tmax;
   assign target = st_r.tgt;
endmodule // ors_apb_regs
`default_nettype wire

// ---- testbench/ors_seq_properties.sv ----
// checker: timing relations at the sequencer ports
`default_nettype none
module ors_seq_properties
   import ors_pkg::*;
(
   // clock, reset, apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // lines and levels
   input wire logic run_oe,
   input wire logic timebase_oe,
   input wire logic input_above_on,
   input wire logic input_below_off,
   input wire logic uv_comp_raw,
   input wire logic uv_filtered,
   input wire logic oc_active,
   input wire logic gpio_oe,
   // power stage
   input wire logic [15:0] ref_target,
   input wire logic [15:0] ref_dac,
   input wire logic force_discontinuous
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] raw_ok_r;
   logic [9:0] raw_ok_nxt;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////////
   // quiet time of raw uv, saturating so it never wraps
   always_comb
      raw_ok_nxt = uv_comp_raw ? 10'h000 : raw_ok_r + {9'h000, raw_ok_r != 10'h3ff};
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         raw_ok_r <= 10'h000;
      else
         raw_ok_r <= raw_ok_nxt;
   ////////////////////////////////////////////////////////////////////////////////
   AST_RUN_HOLD: assert property ((run_oe && !input_above_on)[*4] |=> run_oe)
      else $error("run line released without input ok");
   AST_OFF_PULL: assert property (input_below_off[*8] |-> timebase_oe && run_oe && gpio_oe)
      else $error("lines not pulled low below off threshold");
   AST_APB_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("apb answer not after one wait state");
   AST_RDY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_RAMP_FDCM: assert property ($changed(ref_target) |-> force_discontinuous)
      else $error("target moved outside discontinuous mode");
   AST_STEP_GAP: assert property ($changed(ref_target) |=> $stable(ref_target)[*4])
      else $error("ramp steps closer than one tick");
   AST_DAC_LSB: assert property ($changed(ref_dac) |-> ref_dac - $past(ref_dac) == 16'h0001
      || $past(ref_dac) - ref_dac == 16'h0001)
      else $error("dac moved by more than one lsb");
   AST_DAC_GAP: assert property ($changed(ref_dac) |=> $stable(ref_dac)[*8])
      else $error("dac stepped faster than servo period");
   AST_FDCM_EXIT: assert property ($fell(force_discontinuous) |-> !(uv_filtered && oc_active))
      else $error("left discontinuous mode with faults present");
   AST_GPIO_GLITCH: assert property ($fell(gpio_oe) |-> !uv_filtered || raw_ok_r > 10'h258)
      else $error("gpio released without deglitch");
endmodule // ors_seq_properties
`default_nettype wire

// ---- testbench/ors_peer_model.sv ----
// peer controller model on the shared run and timebase lines
`default_nettype none
module ors_peer_model
(
   // control and line level
   input wire logic peer_init,
   input wire logic run_level,
   // open-drain pulls
   output logic run_pull,
   output logic tb_pull
);
   timeunit 1ns;
   timeprecision 1ns;
   assign run_pull = !peer_init;
   // shared tick, still while run low
   initial
   begin
      tb_pull = 1'b0;
      #13;
      forever
      begin
         #400;
         tb_pull = run_level ? !tb_pull : 1'b0;
      end
   end
endmodule // ors_peer_model
`default_nettype wire

// ---- testbench/testbench.sv ----
// testbench: sequencer against a peer controller
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import ors_pkg::*;
   typedef struct packed {logic [32:0] e; logic [32:0] m;} ors_note_s;
   localparam int DLY = 3;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic input_above_on = 1'b0;
   logic input_below_off = 1'b0;
   logic uv_comp_raw = 1'b0;
   logic uv_filtered = 1'b0;
   logic [15:0] adc_reading = 16'h0;
   logic oc_active = 1'b0;
   logic peer_init = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, run_oe, timebase_oe, gpio_oe, force_discontinuous, run_pull, tb_pull;
   logic [15:0] ref_target, ref_dac, vset, d;
   logic [1:0] conv_mode;
   logic [15:0] rnd = 16'h0031;
   ors_note_s q[$];
   ors_note_s nt;
   int err_count = 0;
   int checks_done = 0;
   wire run_lvl = !(run_oe || run_pull);
   wire tb_lvl = !(timebase_oe || tb_pull);
   always #50 pclk = ~pclk;
   ors_sequencer #(.SERVO_CYCLES(20), .TMAX_TICK_CYCLES(5)) u_dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .run_in(run_lvl),
      .run_out(), .run_oe(run_oe), .timebase_in(tb_lvl), .timebase_out(),
      .timebase_oe(timebase_oe), .input_above_on(input_above_on),
      .input_below_off(input_below_off), .uv_comp_raw(uv_comp_raw), .uv_filtered(uv_filtered),
      .oc_active(oc_active), .adc_reading(adc_reading), .gpio_out(), .gpio_oe(gpio_oe),
      .ref_target(ref_target), .ref_dac(ref_dac), .force_discontinuous(force_discontinuous),
      .conv_mode(conv_mode));
   ors_peer_model u_peer (.peer_init(peer_init), .run_level(run_lvl), .run_pull(run_pull),
      .tb_pull(tb_pull));
   ////////////////////////////////////////////////////////////////////////////////
   function logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task chk(input string n, input logic [32:0] e, input logic [32:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] dt, input logic [32:0] e,
      input logic [32:0] m);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dt;
      q.push_back('{e, m});
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] dt);
      apb(1'b1, a, dt, 33'h0, 33'h1_0000_0000);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {1'b0, e}, 33'h1_ffff_ffff);
   endtask
   task ramp(input int steps);
      logic [15:0] last;
      logic tbp;
      int tb_e;
      int ch;
      last = ref_target;
      tbp = tb_lvl;
      tb_e = 0;
      ch = 0;
      peer_init <= 1'b1;
      for (int n = 0; n < 3000 && (ref_target !== vset || force_discontinuous !== 1'b0); n++)
      begin
         @(posedge pclk);
         if (n == 150)
         begin
            chk("fdcm_oc", oc_active, force_discontinuous);
            oc_active <= 1'b0;
         end
         if (run_lvl && tb_lvl && !tbp && ch == 0)
            tb_e++;
         tbp = tb_lvl;
         if (ref_target !== last)
            ch++;
         last = ref_target;
      end
      chk("delay_ticks", 1'b1, tb_e >= DLY && tb_e <= DLY + 2);
      chk("ramp_steps", steps, ch);
      chk("ref_target", vset, ref_target);
      chk("force_discontinuous", 1'b0, force_discontinuous);
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge pclk)
      if (psel && penable && pready === 1'b1 && q.size() > 0)
      begin
         nt = q.pop_front();
         chk("pslverr_prdata", nt.e, {pslverr, prdata} & nt.m);
      end
   initial
   begin
      #2_000_000;
      err_count++;
      $display("Error watchdog expected finish seen hang");
      print_verdict();
   end
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++)
         rd(12'(4 * i), 32'h0);
      apb(1'b0, 12'h020, 32'h0, 33'h1_0000_0000, 33'h1_ffff_ffff);
      apb(1'b1, OFS_DAC, 32'h1234, 33'h0, 33'h1_0000_0000);
      rd(OFS_DAC, 32'h0);
      rnd = lfsr(rnd);
      vset = rnd | 16'h0100;
      wr(OFS_DELAY, DLY);
      wr(OFS_RISE, 32'h5);
      wr(OFS_VSET, {16'h0, vset});
      input_above_on <= 1'b1;
      repeat (20) @(posedge pclk);
      chk("run_oe", 1'b1, run_oe);
      wr(OFS_CTRL, 32'h0000_0201);
      repeat (20) @(posedge pclk);
      chk("run_level", 1'b0, run_lvl);
      apb(1'b0, OFS_STAT, 32'h0, {25'h0, 1'b1, 4'h0, ORS_WAIT_RUN}, 33'h1_0000_0087);
      ramp(5);
      chk("conv_mode", 2'b10, conv_mode);
      chk("gpio_oe", 1'b0, gpio_oe);
      input_below_off <= 1'b1;
      repeat (10) @(posedge pclk);
      chk("timebase_oe", 1'b1, timebase_oe);
      apb(1'b0, OFS_STAT, 32'h0, {30'h0, ORS_OFF}, 33'h1_0000_0007);
      input_below_off <= 1'b0;
      input_above_on <= 1'b0;
      repeat (30) @(posedge pclk);
      chk("run_oe", 1'b1, run_oe);
      rnd = lfsr(rnd);
      vset = rnd | 16'h0100;
      wr(OFS_VSET, {16'h0, vset});
      wr(OFS_RISE, 32'h2);
      oc_active <= 1'b1;
      input_above_on <= 1'b1;
      ramp(1);
      repeat (60) @(posedge pclk);
      rd(OFS_DAC, 32'h0);
      wr(OFS_TARGET, 32'h40);
      adc_reading <= rnd & 16'h003f;
      wr(OFS_CTRL, 32'h0000_4201);
      repeat (70) @(posedge pclk);
      chk("dac_up", 1'b1, ref_dac >= 16'h1 && ref_dac <= 16'h5);
      adc_reading <= 16'h0040;
      repeat (30) @(posedge pclk);
      d = ref_dac;
      repeat (80) @(posedge pclk);
      chk("dac_hold", d, ref_dac);
      adc_reading <= 16'h0050;
      repeat (50) @(posedge pclk);
      chk("dac_down", 1'b1, ref_dac < d);
      wr(OFS_CTRL, 32'h0000_0203);
      d = ref_dac;
      repeat (60) @(posedge pclk);
      chk("dac_off", d, ref_dac);
      uv_comp_raw <= 1'b1;
      repeat (20) @(posedge pclk);
      uv_comp_raw <= 1'b0;
      repeat (10) @(posedge pclk);
      chk("gpio_glitch", 1'b0, gpio_oe);
      uv_comp_raw <= 1'b1;
      repeat (800) @(posedge pclk);
      chk("gpio_pull", 1'b1, gpio_oe);
      uv_comp_raw <= 1'b0;
      repeat (800) @(posedge pclk);
      chk("gpio_release", 1'b0, gpio_oe);
      wr(OFS_CTRL, 32'h0000_0201);
      uv_filtered <= 1'b1;
      repeat (20) @(posedge pclk);
      chk("gpio_filtered", 1'b1, gpio_oe);
      print_verdict();
   end
endmodule // testbench
bind ors_sequencer ors_seq_properties u_props (.*);
`default_nettype wire
